// ---- rtl/tco_pkg.sv ----
// register map, field layout and reset values of the timer/counter
package tco_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ADDR_W       = 8;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_CMPA     = 8'h04;
  localparam logic [7:0]  OFS_CAPB     = 8'h08;
  localparam logic [7:0]  OFS_COUNT    = 8'h0c;
  localparam logic [7:0]  OFS_STATUS   = 8'h10;
  localparam logic [7:0]  OFS_MASK     = 8'h14;
  // control register fields
  localparam int unsigned CTRL_MODE_LO = 0;
  localparam int unsigned CTRL_EDGE    = 2;
  localparam int unsigned CTRL_CMD     = 3;
  // status / mask fields
  localparam int unsigned ST_W         = 3;
  localparam int unsigned ST_MATCH     = 0;
  localparam int unsigned ST_CAPT      = 1;
  localparam int unsigned ST_OVF       = 2;
  // reset values and the overflow mark
  localparam logic [7:0]  RST_COUNT    = 8'h00;
  localparam logic [7:0]  RST_CMPA     = 8'hff;
  localparam logic [7:0]  RST_CAPB     = 8'h00;
  localparam logic [2:0]  RST_MASK     = 3'h0;
  localparam logic [7:0]  OVF_MARK     = 8'hff;
  // operating modes, gray along timer -> counter -> capture
  typedef enum logic [1:0] {
    TCO_TIMER   = 2'b00,
    TCO_COUNTER = 2'b01,
    TCO_CAPTURE = 2'b11,
    TCO_STOP    = 2'b10
  } tco_mode_e;
endpackage : tco_pkg

// ---- rtl/tco_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module tco_pin_sync (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
    logic fall;
    logic [1:0] fill;
  } tco_sync_s;

  tco_sync_s r;
  tco_sync_s next_r;

  always_comb begin
    next_r      = r;
    next_r.s1   = pin;
    next_r.s2   = r.s1;
    next_r.s3   = r.s2;
    next_r.rise = 1'b0;
    next_r.fall = 1'b0;
    // level follows the pin while the stages fill after reset, so no false edge;
    // afterwards a change counts once stages two and three agree
    if (r.fill != 2'h3) begin
      next_r.fill = r.fill + 2'h1;
      next_r.lvl  = r.s2;
    end else if (r.s2 == r.s3 && r.s3 != r.lvl) begin
      next_r.lvl  = r.s3;
      next_r.rise = r.s3;
      next_r.fall = ~r.s3;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.lvl;
  assign rise  = r.rise;
  assign fall  = r.fall;
endmodule : tco_pin_sync
`default_nettype wire

// ---- rtl/tco_timer.sv ----
// 8-bit timer/counter with compare, two capture registers and apb access
//
// Notes on behaviour
// - timer mode counts clock, clears on compare match
// - counter mode counts one selected pin edge
// - counter match raises interrupt, clears, resumes
// - capture command copies count, then self-clears
// - capture mode counter runs freely from clock
// - primary edge captures to A, clears, interrupts
// - opposite edge captures to B, keeps counting
// - overflow loads FFH into A, interrupts
// - captures halt until A is read
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module tco_timer
  import tco_pkg::*;
#(
  parameter int unsigned TICK_DIV = 1
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        count_input_pin,
  output logic             irq
);
  localparam int unsigned DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  if (TICK_DIV < 1) begin : g_bad_tick_div
    $error("TICK_DIV must be at least 1");
  end

  typedef struct packed {
    logic [DATA_W-1:0] count;
    logic [DATA_W-1:0] compare_capture_a;
    logic [DATA_W-1:0] capture_b;
    tco_mode_e         mode;
    logic              count_edge_select;
    logic              capture_command_bit;
    logic              armed;
    logic [ST_W-1:0]   status;
    logic [ST_W-1:0]   mask;
    logic [DIV_W-1:0]  div;
    logic              tick;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic              irq;
  } tco_state_s;

  tco_state_s r;
  tco_state_s next_r;

  logic pin_rise;
  logic pin_fall;
  logic prim_edge;
  logic opp_edge;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic [7:0] addr;
  logic [ST_W-1:0] ev;

  tco_pin_sync u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pin     (count_input_pin),
    .level   (),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // edge select 0 makes the rising edge primary
  assign prim_edge = r.count_edge_select ? pin_fall : pin_rise;
  assign opp_edge  = r.count_edge_select ? pin_rise : pin_fall;
  assign acc_done  = psel & penable & r.pready;
  assign wr_done   = acc_done & pwrite;
  assign rd_done   = acc_done & ~pwrite;
  assign addr      = paddr[7:0];

  always_comb begin
    next_r      = r;
    ev          = '0;
    next_r.tick = 1'b0;
    if (r.div == DIV_W'(TICK_DIV - 1)) begin
      next_r.div  = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.div = r.div + 1'b1;
    end

    case (r.mode)
      TCO_TIMER: begin
        if (r.tick) begin
          if (r.count == r.compare_capture_a) begin
            next_r.count = '0;
            ev[ST_MATCH] = 1'b1;
          end else begin
            next_r.count = r.count + 1'b1;
          end
        end
      end
      TCO_COUNTER: begin
        if (prim_edge) begin
          if (r.count == r.compare_capture_a) begin
            next_r.count = '0;
            ev[ST_MATCH] = 1'b1;
          end else begin
            next_r.count = r.count + 1'b1;
          end
        end
      end
      TCO_CAPTURE: begin
        if (r.tick) begin
          next_r.count = r.count + 1'b1;
        end
        if (r.armed) begin
          if (prim_edge) begin
            next_r.compare_capture_a = r.count;
            next_r.count             = '0;
            next_r.armed             = 1'b0;
            ev[ST_CAPT]              = 1'b1;
          end else if (r.tick && r.count == OVF_MARK) begin
            next_r.compare_capture_a = OVF_MARK;
            next_r.armed             = 1'b0;
            ev[ST_OVF]               = 1'b1;
          end
          if (opp_edge) begin
            next_r.capture_b = r.count;
          end
        end
      end
      default: begin
      end
    endcase

    // command capture waits one cycle after the write, then self-clears
    if (r.capture_command_bit) begin
      next_r.capture_b           = r.count;
      next_r.capture_command_bit = 1'b0;
    end

    // apb slave: one wait state, effects at the completing edge
    next_r.pready  = 1'b0;
    next_r.pslverr = 1'b0;
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = '0;
      if (addr == OFS_CTRL) begin
        next_r.prdata[CTRL_MODE_LO +: 2] = r.mode;
        next_r.prdata[CTRL_EDGE]         = r.count_edge_select;
        next_r.prdata[CTRL_CMD]          = r.capture_command_bit;
      end else if (addr == OFS_CMPA) begin
        next_r.prdata[DATA_W-1:0] = r.compare_capture_a;
      end else if (addr == OFS_CAPB) begin
        next_r.prdata[DATA_W-1:0] = r.capture_b;
      end else if (addr == OFS_COUNT) begin
        next_r.prdata[DATA_W-1:0] = r.count;
      end else if (addr == OFS_STATUS) begin
        next_r.prdata[ST_W-1:0] = r.status;
      end else if (addr == OFS_MASK) begin
        next_r.prdata[ST_W-1:0] = r.mask;
      end else begin
        next_r.pslverr = 1'b1;
      end
    end

    if (wr_done) begin
      if (addr == OFS_CTRL) begin
        next_r.mode              = tco_mode_e'(pwdata[CTRL_MODE_LO +: 2]);
        next_r.count_edge_select = pwdata[CTRL_EDGE];
        // command only honoured in timer and counter modes
        if (pwdata[CTRL_CMD] && (r.mode == TCO_TIMER || r.mode == TCO_COUNTER)) begin
          next_r.capture_command_bit = 1'b1;
        end
      end else if (addr == OFS_CMPA) begin
        next_r.compare_capture_a = pwdata[DATA_W-1:0];
      end else if (addr == OFS_MASK) begin
        next_r.mask = pwdata[ST_W-1:0];
      end
    end
    if (rd_done && addr == OFS_CMPA) begin
      next_r.armed = 1'b1;
    end

    // a read clears only the bits it returned, and a same-cycle event wins
    if (rd_done && addr == OFS_STATUS) begin
      next_r.status = (r.status & ~r.prdata[ST_W-1:0]) | ev;
    end else begin
      next_r.status = r.status | ev;
    end
    next_r.irq = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r                     <= '0;
      r.count               <= RST_COUNT;
      r.compare_capture_a   <= RST_CMPA;
      r.capture_b           <= RST_CAPB;
      r.mode                <= TCO_TIMER;
      r.capture_command_bit <= 1'b0;
      r.armed               <= 1'b1;
      r.mask                <= RST_MASK;
    end else begin
      r <= next_r;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = r.pready;
  assign pslverr = r.pslverr;
  assign irq     = r.irq;

  logic wr_cmpa;
  assign wr_cmpa = wr_done && addr == OFS_CMPA;

  property p_timer_match;
    r.mode == TCO_TIMER && r.tick && r.count == r.compare_capture_a && !wr_done
      |=> r.count == 8'h00 && r.status[ST_MATCH];
  endproperty
  a_timer_match: assert property (p_timer_match) else $error("timer match did not clear");

  property p_counter_hold;
    r.mode == TCO_COUNTER && !prim_edge && !wr_done |=> $stable(r.count);
  endproperty
  a_counter_hold: assert property (p_counter_hold) else $error("counter moved without edge");

  property p_counter_match;
    r.mode == TCO_COUNTER && prim_edge && r.count == r.compare_capture_a && !wr_done
      |=> r.count == 8'h00 && r.status[ST_MATCH];
  endproperty
  a_counter_match: assert property (p_counter_match) else $error("counter match missed");

  property p_cmd_capture;
    r.capture_command_bit |=> !r.capture_command_bit && r.capture_b == $past(r.count);
  endproperty
  a_cmd_capture: assert property (p_cmd_capture) else $error("command capture wrong");

  property p_free_run;
    r.mode == TCO_CAPTURE && r.tick && !(r.armed && prim_edge) && !wr_done
      |=> r.count == $past(r.count) + 8'h01;
  endproperty
  a_free_run: assert property (p_free_run) else $error("capture counter not free running");

  property p_prim_capture;
    r.mode == TCO_CAPTURE && r.armed && prim_edge && !wr_done
      |=> r.compare_capture_a == $past(r.count) && r.count == 8'h00 && r.status[ST_CAPT] && !r.armed;
  endproperty
  a_prim_capture: assert property (p_prim_capture) else $error("primary capture wrong");

  property p_opp_capture;
    r.mode == TCO_CAPTURE && r.armed && opp_edge && !r.capture_command_bit
      |=> r.capture_b == $past(r.count);
  endproperty
  a_opp_capture: assert property (p_opp_capture) else $error("opposite capture wrong");

  property p_overflow;
    r.mode == TCO_CAPTURE && r.armed && !prim_edge && r.tick && r.count == 8'hff && !wr_done
      |=> r.compare_capture_a == 8'hff && r.status[ST_OVF];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not marked");

  property p_halt;
    r.mode == TCO_CAPTURE && !r.armed && !wr_cmpa |=> $stable(r.compare_capture_a);
  endproperty
  a_halt: assert property (p_halt) else $error("capture while halted");

  property p_edge_sel;
    r.mode == TCO_COUNTER && r.count_edge_select && pin_rise && !pin_fall && !wr_done
      |=> $stable(r.count);
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("counted the wrong edge");

  property p_irq_level;
    r.irq == |(r.status & r.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_timer_step;
    r.mode == TCO_TIMER && r.tick && r.count != r.compare_capture_a && !wr_done
      |=> r.count == $past(r.count) + 8'h01;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer did not step");

  property p_counter_step;
    r.mode == TCO_COUNTER && prim_edge && r.count != r.compare_capture_a && !wr_done
      |=> r.count == $past(r.count) + 8'h01;
  endproperty
  a_counter_step: assert property (p_counter_step) else $error("counter did not step");

  property p_cmd_refused;
    wr_done && addr == OFS_CTRL && pwdata[CTRL_CMD] && !(r.mode == TCO_TIMER || r.mode == TCO_COUNTER)
      |=> !r.capture_command_bit;
  endproperty
  a_cmd_refused: assert property (p_cmd_refused) else $error("capture command taken in wrong mode");

  property p_halt_events;
    r.mode == TCO_CAPTURE && !r.armed |-> !ev[ST_CAPT] && !ev[ST_OVF];
  endproperty
  a_halt_events: assert property (p_halt_events) else $error("event while halted");

  property p_halt_b;
    r.mode == TCO_CAPTURE && !r.armed && !r.capture_command_bit |=> $stable(r.capture_b);
  endproperty
  a_halt_b: assert property (p_halt_b) else $error("second capture while halted");

  property p_rearm;
    rd_done && addr == OFS_CMPA |=> r.armed;
  endproperty
  a_rearm: assert property (p_rearm) else $error("read did not re-arm");

  property p_stop_hold;
    r.mode == TCO_STOP |=> $stable(r.count);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

  property p_capt_sticky;
    r.status[ST_CAPT] && !(rd_done && addr == OFS_STATUS) |=> r.status[ST_CAPT];
  endproperty
  a_capt_sticky: assert property (p_capt_sticky) else $error("capture flag lost");

  property p_ovf_sticky;
    r.status[ST_OVF] && !(rd_done && addr == OFS_STATUS) |=> r.status[ST_OVF];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

  property p_edge_sel_rise;
    r.mode == TCO_COUNTER && !r.count_edge_select && pin_fall && !pin_rise && !wr_done
      |=> $stable(r.count);
  endproperty
  a_edge_sel_rise: assert property (p_edge_sel_rise) else $error("counted the falling edge");

  c_prim_capture: cover property (r.mode == TCO_CAPTURE && r.armed && prim_edge);
  c_overflow:     cover property (r.status[ST_OVF]);
  c_timer_match:  cover property (r.mode == TCO_TIMER && r.status[ST_MATCH] && r.irq);
  c_cmd_capture:  cover property (r.capture_command_bit);
endmodule : tco_timer
`default_nettype wire

// ---- verification/tco_pin_model.sv ----
// pulse source model for the count input pin
`timescale 1ns/1ps
`default_nettype none
module tco_pin_model (
  input  wire logic ref_clk,
  output logic      pin
);
  initial pin = 1'b0;
  // holds each level for n clocks, long enough to pass the pin filter
  task automatic level(input logic lvl, input int n);
    @(posedge ref_clk);
    pin <= lvl;
    repeat (n - 1) @(posedge ref_clk);
  endtask : level
  task automatic pulse;
    level(1'b1, 8);
    level(1'b0, 8);
  endtask : pulse
  // primary edge, opposite edge after h, next primary edge after p
  task automatic wave(input int h, input int p);
    level(1'b1, h);
    level(1'b0, p - h);
    level(1'b1, 12);
  endtask : wave
endmodule : tco_pin_model
`default_nettype wire

// ---- verification/timer_counter_one_capture_bench.sv ----
// self-checking bench of the timer/counter
`timescale 1ns/1ps
`default_nettype none
module timer_counter_one_capture_bench;
  import tco_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] held;
  logic        err_seen;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          c, k, h, p, t1, t_irq;

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  tco_timer #(.TICK_DIV(1)) tco_timer_inst (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_input_pin(pin), .irq(irq)
  );
  tco_pin_model tco_pin_model_inst (.ref_clk(ref_clk), .pin(pin));

  function automatic logic [31:0] ctrl(tco_mode_e m, logic e, logic cmd);
    return {28'h0, cmd, e, m};
  endfunction : ctrl
  // pin synchroniser may shift a capture up to two ticks low or one tick high
  function automatic logic [31:0] near(logic [31:0] s, int e);
    return {31'h0, (s + 32'h2 >= e) && (s <= e + 1)};
  endfunction : near

  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge ref_clk);
    if (i == 20) begin
      errors++;
      report_and_stop();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_reg(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd_reg
  task automatic wait_irq;
    int i;
    repeat (2) @(posedge ref_clk);
    for (i = 0; i < 600 && irq !== 1'b1; i++) @(posedge ref_clk);
    if (i == 600) begin
      errors++;
      report_and_stop();
    end
    t_irq = cyc;
  endtask : wait_irq

  initial begin
    void'($urandom(8709));
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_reg(OFS_CMPA);
    check(rd, {24'h0, RST_CMPA});
    rd_reg(OFS_CAPB);
    check(rd, {24'h0, RST_CAPB});
    rd_reg(OFS_CTRL);
    check(rd, ctrl(TCO_TIMER, 1'b0, 1'b0));
    rd_reg(8'h40);
    check({31'h0, err_seen}, 32'h1);
    $display("test reset done");
    c = $urandom_range(30, 8);
    apb(1'b1, OFS_CMPA, 32'(c));
    apb(1'b1, OFS_MASK, 32'h1);
    rd_reg(OFS_STATUS);
    wait_irq();
    rd_reg(OFS_STATUS);
    wait_irq();
    t1 = t_irq;
    rd_reg(OFS_STATUS);
    check(rd, 32'h1);
    wait_irq();
    check(32'(t_irq - t1), 32'(c + 1));
    $display("test timer done");
    apb(1'b1, OFS_CTRL, ctrl(TCO_COUNTER, 1'b0, 1'b0));
    rd_reg(OFS_COUNT);
    apb(1'b1, OFS_CMPA, rd);
    rd_reg(OFS_STATUS);
    tco_pin_model_inst.pulse();
    rd_reg(OFS_STATUS);
    check(rd, 32'h1);
    apb(1'b1, OFS_CMPA, 32'hff);
    k = $urandom_range(6, 1);
    repeat (k) tco_pin_model_inst.pulse();
    rd_reg(OFS_COUNT);
    check(rd, 32'(k));
    tco_pin_model_inst.level(1'b1, 8);
    rd_reg(OFS_COUNT);
    check(rd, 32'(k + 1));
    tco_pin_model_inst.level(1'b0, 8);
    apb(1'b1, OFS_CTRL, ctrl(TCO_COUNTER, 1'b1, 1'b0));
    tco_pin_model_inst.level(1'b1, 8);
    rd_reg(OFS_COUNT);
    check(rd, 32'(k + 1));
    tco_pin_model_inst.level(1'b0, 8);
    apb(1'b1, OFS_CTRL, ctrl(TCO_COUNTER, 1'b1, 1'b1));
    rd_reg(OFS_CAPB);
    check(rd, 32'(k + 2));
    rd_reg(OFS_CTRL);
    check(rd, ctrl(TCO_COUNTER, 1'b1, 1'b0));
    $display("test counter done");
    h = $urandom_range(60, 20);
    p = h + $urandom_range(60, 20);
    apb(1'b1, OFS_MASK, 32'h6);
    apb(1'b1, OFS_CTRL, ctrl(TCO_CAPTURE, 1'b0, 1'b0));
    rd_reg(OFS_CMPA);
    fork
      tco_pin_model_inst.wave(h, p);
      begin
        // re-arm after the first primary edge so the opposite edge counts
        repeat (10) @(posedge ref_clk);
        rd_reg(OFS_CMPA);
      end
    join
    check({31'h0, irq}, 32'h1);
    rd_reg(OFS_CMPA);
    check(near(rd, p), 32'h1);
    rd_reg(OFS_CAPB);
    check(near(rd, h), 32'h1);
    rd_reg(OFS_STATUS);
    check(rd, 32'h2);
    repeat (300) @(posedge ref_clk);
    check({31'h0, irq}, 32'h1);
    tco_pin_model_inst.level(1'b0, 8);
    tco_pin_model_inst.level(1'b1, 8);
    rd_reg(OFS_STATUS);
    check(rd, 32'h4);
    rd_reg(OFS_CAPB);
    check(near(rd, h), 32'h1);
    rd_reg(OFS_CMPA);
    check(rd, {24'h0, OVF_MARK});
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    $display("test capture done");
    apb(1'b1, OFS_CTRL, ctrl(TCO_STOP, 1'b0, 1'b1));
    rd_reg(OFS_CTRL);
    check(rd, ctrl(TCO_STOP, 1'b0, 1'b0));
    rd_reg(OFS_CAPB);
    check(near(rd, h), 32'h1);
    rd_reg(OFS_COUNT);
    held = rd;
    repeat (20) @(posedge ref_clk);
    rd_reg(OFS_COUNT);
    check(rd, held);
    $display("test stop done");
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    rstn <= 1'b1;
    rd_reg(OFS_CAPB);
    check(rd, {24'h0, RST_CAPB});
    rd_reg(OFS_CTRL);
    check(rd, ctrl(TCO_TIMER, 1'b0, 1'b0));
    rd_reg(OFS_STATUS);
    check(rd, 32'h0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : timer_counter_one_capture_bench
`default_nettype wire
